// file: design/tws_pkg.sv
// Shared constants and types for the two-wire serial EEPROM slave
package tws_pkg;

	// Array organisation
	localparam int ADDR_W     = 9;
	localparam int MEM_BYTES  = 512;
	localparam int PAGE_BYTES = 16;
	localparam int PIDX_W     = 4;
	localparam int PAGE_W     = ADDR_W - PIDX_W;

	// Slave address byte layout
	localparam logic [3:0] DEV_TYPE_CODE = 4'h5; // Arbitrary value, not a real part code
	localparam int SA_TYPE_MSB = 7;
	localparam int SA_TYPE_LSB = 4;
	localparam int SA_PIN_HI   = 3;
	localparam int SA_PIN_LO   = 2;
	localparam int SA_BLOCK    = 1;
	localparam int SA_RW       = 0;

	// Bit counting
	localparam logic [3:0] LAST_BIT_CNT = 4'h7;

	// Synchronised pin vector layout
	localparam int PIN_SCL  = 0;
	localparam int PIN_SDA  = 1;
	localparam int PIN_AHI  = 2;
	localparam int PIN_ALO  = 3;
	localparam int PIN_WLCK = 4;
	localparam int PIN_BIT  = 5;
	localparam int PIN_TOG  = 6;
	localparam int PIN_N    = 7;

	// Self-timed write cycle: longest time rounds down
	localparam int CLK_PERIOD_PS   = 4000;
	localparam int WRITE_TIME_MS   = 5;
	localparam int WRITE_CYCLES    = (WRITE_TIME_MS * 1000000) / (CLK_PERIOD_PS / 1000);

	typedef enum logic [3:0]
	{
		ST_IDLE     = 4'b0000,
		ST_ADDR     = 4'b0001,
		ST_ACK_ADDR = 4'b0010,
		ST_WORD     = 4'b0011,
		ST_ACK_WORD = 4'b0100,
		ST_WDATA    = 4'b0101,
		ST_ACK_DATA = 4'b0110,
		ST_RDATA    = 4'b0111,
		ST_RACK     = 4'b1000
	} tws_state_t;

	typedef struct packed
	{
		logic [ADDR_W-1:0] addr;
		logic [7:0]        data;
	} tws_wr_t;

endpackage

// file: design/tws_sync.sv
// Two-flop synchroniser, one pair per bit
`timescale 1ns/100ps
module tws_sync
	import tws_pkg::*;
#(
	parameter int W = 1
)
(
	// Clock and reset
	input  wire logic         ref_clk,
	input  wire logic         nrst,
	// Data
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	initial
	begin
		if (W < 1)
			$error("tws_sync: W must be at least 1");
	end

	genvar i;
	generate
		for (i = 0; i < W; i++)
		begin : g_bit
			logic meta;
			always_ff @(posedge ref_clk or negedge nrst)
			begin
				if (!nrst)
				begin
					meta <= 1'b0;
					q[i] <= 1'b0;
				end
				else
				begin
					meta <= d[i];
					q[i] <= meta;
				end
			end
		end
	endgenerate

endmodule // tws_sync

// file: design/tws_store.sv
// Page buffer, memory array and self-timed write cycle
`timescale 1ns/100ps
module tws_store
	import tws_pkg::*;
#(
	parameter int WR_CYCLES = WRITE_CYCLES
)
(
	// Clock and reset
	input  wire logic              ref_clk,
	input  wire logic              nrst,
	// Page buffer load
	input  wire logic              wr_en,
	input  wire tws_wr_t           wr,
	input  wire logic              commit,
	input  wire logic              discard,
	input  wire logic              lock,
	// Read port and status
	input  wire logic [ADDR_W-1:0] rd_addr,
	output logic      [7:0]        rd_data,
	output logic                   busy
);

	localparam int CW = $clog2(WR_CYCLES + 1);

	initial
	begin
		if (WR_CYCLES < PAGE_BYTES)
			$error("tws_store: WR_CYCLES must cover one pass over the page");
	end

	logic [7:0]            mem [MEM_BYTES];
	logic [7:0]            pbuf [PAGE_BYTES];
	logic [PAGE_BYTES-1:0] pvalid;
	logic [PAGE_W-1:0]     page;
	logic [CW-1:0]         tmr;
	logic                  lock_q;

	wire  [PIDX_W-1:0]     cidx   = tmr[PIDX_W-1:0];
	wire                   in_cpy = busy && (tmr < CW'(PAGE_BYTES));
	wire                   mem_we = in_cpy && pvalid[cidx] && !lock_q; // see [RQ25]
	wire                   done   = busy && (tmr == CW'(WR_CYCLES - 1)); // see [RQ24]

	assign rd_data = mem[rd_addr];

	// Later bytes to the same slot overwrite earlier ones, see [RQ14]
	always_ff @(posedge ref_clk)
	begin
		if (wr_en)
			pbuf[wr.addr[PIDX_W-1:0]] <= wr.data;
	end

	// Every loaded page byte goes to the array in one busy period unless locked, see [RQ15]
	always_ff @(posedge ref_clk)
	begin
		if (mem_we)
			mem[{page, cidx}] <= pbuf[cidx];
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			busy   <= 1'b0;
			tmr    <= '0;
			lock_q <= 1'b0;
		end
		else if (commit && !busy)
		begin
			busy   <= 1'b1;
			tmr    <= '0;
			lock_q <= lock;
		end
		else if (done)
			busy <= 1'b0;
		else if (busy)
			tmr <= tmr + CW'(1);
	end

	genvar e;
	generate
		for (e = 0; e < PAGE_BYTES; e++)
		begin : g_valid
			always_ff @(posedge ref_clk or negedge nrst)
			begin
				if (!nrst)
					pvalid[e] <= 1'b0;
				else if (wr_en && wr.addr[PIDX_W-1:0] == PIDX_W'(e))
					pvalid[e] <= 1'b1;
				else if (discard || done)
					pvalid[e] <= 1'b0;
			end
		end
	endgenerate

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			page <= '0;
		else if (wr_en)
			page <= wr.addr[ADDR_W-1:PIDX_W];
	end

endmodule // tws_store

// file: design/tws_eeprom.sv
// Two-wire serial EEPROM slave: protocol engine and pin logic
//
// Contract
// [RQ1] Falling SDA with SCL high is start
// [RQ2] Rising SDA with SCL high is stop
// [RQ3] SDA changes only while SCL is low
// [RQ4] SDA change under high SCL is never data
// [RQ5] Master starts idle, frames with start/stop
// [RQ6] Acknowledge each addressed byte on ninth clock
// [RQ7] Type code and two pin bits must match
// [RQ8] Block bit is address bit eight
// [RQ9] Address bit zero: one read, zero write
// [RQ10] Byte write: address, word, data, stop programs
// [RQ11] No response while internal write runs
// [RQ12] Up to sixteen bytes per page write
// [RQ13] Write increments only low four address bits
// [RQ14] Extra page bytes overwrite earlier ones
// [RQ15] Stop commits whole page in one cycle
// [RQ16] Address not acknowledged while write busy
// [RQ17] Current read uses last address plus one
// [RQ18] Current read wraps to zero; nack ends
// [RQ19] Random read: dummy write, repeated start, read
// [RQ20] Master ack gets next byte; nack ends
// [RQ21] Sequential read rolls over whole array
// [RQ22] Start always resets the protocol state
// [RQ23] Standby when idle and no write running
// [RQ24] Internal write finishes within five milliseconds
// [RQ25] Write lock pin blocks all array changes
// [RQ26] Mismatched address: no ack until next start
// [RQ27] Open-drain SDA, bits sampled on SCL rise
`timescale 1ns/100ps
module tws_eeprom
	import tws_pkg::*;
#(
	parameter int WR_CYCLES = WRITE_CYCLES
)
(
	// Core clock and reset
	input  wire logic ref_clk,
	input  wire logic nrst,
	// Two-wire link
	input  wire logic scl,
	input  wire logic sda_in,
	output logic      sda_out,
	output logic      sda_oe_n,
	// Straps
	input  wire logic hw_addr_pin_hi,
	input  wire logic hw_addr_pin_lo,
	input  wire logic write_lock_pin,
	// Status
	output logic      standby,
	output logic      write_busy
);

	// The store walks the page once per busy period, so shorter cycles cannot work
	initial
	begin
		if (WR_CYCLES < PAGE_BYTES)
			$error("tws_eeprom: WR_CYCLES must be at least one page");
	end

	// Link-clock side: capture SDA on each SCL rise and flag it by toggle
	logic link_bit;
	logic link_tog;

	always_ff @(posedge scl or negedge nrst)
	begin
		if (!nrst)
		begin
			link_bit <= 1'b0;
			link_tog <= 1'b0;
		end
		else
		begin
			link_bit <= sda_in; // see [RQ27]
			link_tog <= ~link_tog;
		end
	end

	// Every pin and link-domain flop enters through the synchroniser
	logic [PIN_N-1:0] pins_s;

	tws_sync #(.W(PIN_N)) u_sync
	(
		.ref_clk (ref_clk),
		.nrst    (nrst),
		.d       ({link_tog, link_bit, write_lock_pin, hw_addr_pin_lo,
		           hw_addr_pin_hi, sda_in, scl}),
		.q       (pins_s)
	);

	logic scl_d;
	logic sda_d;
	logic tog_d;
	logic tog_d2;

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			scl_d  <= 1'b0;
			sda_d  <= 1'b0;
			tog_d  <= 1'b0;
			tog_d2 <= 1'b0;
		end
		else
		begin
			scl_d  <= pins_s[PIN_SCL];
			sda_d  <= pins_s[PIN_SDA];
			tog_d  <= pins_s[PIN_TOG];
			tog_d2 <= tog_d;
		end
	end

	// Line events; the bit event waits one extra cycle so the bit value has settled
	wire scl_s    = pins_s[PIN_SCL];
	wire sda_s    = pins_s[PIN_SDA];
	wire bit_s    = pins_s[PIN_BIT];
	wire start_ev = scl_s && scl_d && sda_d && !sda_s; // see [RQ1] [RQ4]
	wire stop_ev  = scl_s && scl_d && !sda_d && sda_s; // see [RQ2] [RQ4]
	wire scl_fall = scl_d && !scl_s;
	wire bit_ev   = tog_d ^ tog_d2;

	// Protocol state
	tws_state_t        state;
	logic [3:0]        cnt;
	logic [7:0]        shreg;
	logic [7:0]        txb;
	logic [1:0]        phase;
	logic              ack_ok;
	logic              rw;
	logic              blk;
	logic              wrote;
	logic [ADDR_W-1:0] ptr;
	logic              st_wr_en;
	logic              st_commit;
	logic              st_discard;
	tws_wr_t           st_wr;
	logic [7:0]        rd_data;
	logic              busy;

	wire [7:0]        next_shreg = {shreg[6:0], bit_s};
	wire              byte_done  = bit_ev && (cnt == LAST_BIT_CNT);
	wire [ADDR_W-1:0] next_ptr   = ptr + ADDR_W'(1); // see [RQ18] [RQ21]
	wire [ADDR_W-1:0] next_wptr  = {ptr[ADDR_W-1:PIDX_W],
	                                ptr[PIDX_W-1:0] + PIDX_W'(1)}; // see [RQ13]
	wire              type_ok    = next_shreg[SA_TYPE_MSB:SA_TYPE_LSB] == DEV_TYPE_CODE;
	wire              pins_ok    = (next_shreg[SA_PIN_HI] == pins_s[PIN_AHI]) &&
	                               (next_shreg[SA_PIN_LO] == pins_s[PIN_ALO]);
	wire              addr_ack   = type_ok && pins_ok && !busy; // see [RQ7] [RQ11] [RQ16] [RQ26]
	wire              ack_end    = scl_fall && (phase == 2'h1);

	tws_store #(.WR_CYCLES(WR_CYCLES)) u_store
	(
		.ref_clk (ref_clk),
		.nrst    (nrst),
		.wr_en   (st_wr_en),
		.wr      (st_wr),
		.commit  (st_commit),
		.discard (st_discard),
		.lock    (pins_s[PIN_WLCK]),
		.rd_addr (ptr),
		.rd_data (rd_data),
		.busy    (busy)
	);

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state      <= ST_IDLE;
			cnt        <= 4'h0;
			shreg      <= 8'h00;
			txb        <= 8'h00;
			phase      <= 2'h0;
			ack_ok     <= 1'b0;
			rw         <= 1'b0;
			blk        <= 1'b0;
			wrote      <= 1'b0;
			ptr        <= '0;
			sda_oe_n   <= 1'b1;
			st_wr_en   <= 1'b0;
			st_commit  <= 1'b0;
			st_discard <= 1'b0;
			st_wr      <= '0;
		end
		else
		begin
			st_wr_en   <= 1'b0;
			st_commit  <= 1'b0;
			st_discard <= 1'b0;
			if (start_ev)
			begin
				// A start in any state restarts decoding; an unfinished page is dropped
				state      <= ST_ADDR; // see [RQ22] [RQ19]
				cnt        <= 4'h0;
				phase      <= 2'h0;
				sda_oe_n   <= 1'b1;
				st_discard <= wrote;
				wrote      <= 1'b0;
			end
			else if (stop_ev)
			begin
				state     <= ST_IDLE; // see [RQ2] [RQ20]
				sda_oe_n  <= 1'b1;
				st_commit <= wrote; // see [RQ10] [RQ15]
				wrote     <= 1'b0;
			end
			else
			begin
				case (state)
					ST_IDLE:
						sda_oe_n <= 1'b1; // see [RQ1]
					ST_ADDR, ST_WORD, ST_WDATA:
					begin
						if (bit_ev)
						begin
							shreg <= next_shreg;
							cnt   <= cnt + 4'h1;
						end
						if (byte_done)
						begin
							phase <= 2'h0;
							if (state == ST_ADDR)
							begin
								state  <= ST_ACK_ADDR;
								ack_ok <= addr_ack;
								rw     <= next_shreg[SA_RW]; // see [RQ9]
								blk    <= next_shreg[SA_BLOCK];
							end
							else if (state == ST_WORD)
							begin
								state  <= ST_ACK_WORD;
								ack_ok <= 1'b1;
								ptr    <= {blk, next_shreg}; // see [RQ8]
							end
							else
							begin
								state    <= ST_ACK_DATA;
								ack_ok   <= 1'b1;
								st_wr_en <= 1'b1; // see [RQ12] [RQ14]
								st_wr    <= '{addr: ptr, data: next_shreg};
								ptr      <= next_wptr; // see [RQ13]
								wrote    <= 1'b1;
							end
						end
					end
					ST_ACK_ADDR, ST_ACK_WORD, ST_ACK_DATA:
					begin
						// First fall opens the ninth clock, second fall closes it
						if (scl_fall && phase == 2'h0)
						begin
							sda_oe_n <= ~ack_ok; // see [RQ6] [RQ3]
							phase    <= 2'h1;
							if (!ack_ok)
								state <= ST_IDLE; // see [RQ26] [RQ11]
						end
						else if (ack_end)
						begin
							cnt   <= 4'h0;
							phase <= 2'h0;
							if (state == ST_ACK_ADDR && rw)
							begin
								state    <= ST_RDATA; // see [RQ17]
								txb      <= rd_data;
								sda_oe_n <= rd_data[7];
								ptr      <= next_ptr;
							end
							else
							begin
								sda_oe_n <= 1'b1;
								state    <= (state == ST_ACK_ADDR) ? ST_WORD : ST_WDATA;
							end
						end
					end
					ST_RDATA:
					begin
						if (bit_ev)
						begin
							cnt <= cnt + 4'h1;
							if (cnt == LAST_BIT_CNT)
							begin
								state <= ST_RACK;
								phase <= 2'h0;
							end
						end
						if (scl_fall)
						begin
							txb      <= {txb[6:0], 1'b0};
							sda_oe_n <= txb[6]; // see [RQ3] [RQ27]
						end
					end
					ST_RACK:
					begin
						if (scl_fall && phase == 2'h0)
						begin
							sda_oe_n <= 1'b1;
							phase    <= 2'h1;
						end
						else if (bit_ev && phase == 2'h1)
						begin
							if (bit_s)
								state <= ST_IDLE; // see [RQ18] [RQ20]
							else
								phase <= 2'h2;
						end
						else if (scl_fall && phase == 2'h2)
						begin
							state    <= ST_RDATA; // see [RQ20] [RQ21]
							cnt      <= 4'h0;
							phase    <= 2'h0;
							txb      <= rd_data;
							sda_oe_n <= rd_data[7];
							ptr      <= next_ptr;
						end
					end
					default:
					begin
						state    <= ST_IDLE;
						sda_oe_n <= 1'b1;
					end
				endcase
			end
		end
	end

	// Open drain: the data level is always low, only the enable moves.
	// Standby also checks wrote, but the stop clears it, so standby is set for one cycle before busy rises.
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			sda_out    <= 1'b0;
			standby    <= 1'b1;
			write_busy <= 1'b0;
		end
		else
		begin
			sda_out    <= 1'b0; // see [RQ27]
			standby    <= (state == ST_IDLE) && !busy && !wrote; // see [RQ23]
			write_busy <= busy;
		end
	end

endmodule // tws_eeprom

// file: testbench/tws_master.sv
// Two-wire bus master model driving the link clock and open-drain data
`timescale 1ns/100ps
module tws_master
(
	// Link
	output logic      scl,
	output logic      sda_drv,
	input  wire logic sda
);
	// Link clock stands still high between frames
	initial
	begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	// Data moves 45 ns into the low phase, clear of the device output change
	task automatic put_bit(input logic b, output logic r);
		#45 sda_drv = b;
		#17.5 scl = 1'b1;
		#31.25 r = sda;
		#31.25 scl = 1'b0;
	endtask
	task automatic start;
		#45 sda_drv = 1'b1;
		#17.5 scl = 1'b1;
		#62.5 sda_drv = 1'b0;
		#62.5 scl = 1'b0;
	endtask
	task automatic stop;
		#45 sda_drv = 1'b0;
		#17.5 scl = 1'b1;
		#62.5 sda_drv = 1'b1;
		#62.5;
	endtask
	task automatic send(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			put_bit(b[i], r);
		put_bit(1'b1, r);
		ack = !r;
	endtask
	task automatic recv(input logic more, output logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--)
		begin
			put_bit(1'b1, r);
			b[i] = r;
		end
		put_bit(!more, r);
	endtask
endmodule // tws_master

// file: testbench/tws_eeprom_checker.sv
// Concurrent checks on the EEPROM slave pins
`timescale 1ns/100ps
module tws_eeprom_checker
	import tws_pkg::*;
#(
	parameter int WR_CYCLES = WRITE_CYCLES
)
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// Link
	input wire logic scl,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe_n,
	// Straps and status
	input wire logic hw_addr_pin_hi,
	input wire logic hw_addr_pin_lo,
	input wire logic write_lock_pin,
	input wire logic standby,
	input wire logic write_busy
);
	int busy_cnt;
	always_ff @(posedge ref_clk or negedge nrst)
		if (!nrst)
			busy_cnt <= 0;
		else
			busy_cnt <= write_busy ? busy_cnt + 1 : 0;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	AST_OD_LOW: assert property (!sda_oe_n |-> sda_out == 1'b0)
		else $error("sda driven high");
	AST_OE_AFTER_FALL: assert property
		($changed(sda_oe_n) |-> !scl && ($past(scl, 4) || $past(scl, 5)))
		else $error("sda moved away from scl fall");
	AST_ACK_HOLD: assert property ($fell(sda_oe_n) |=> !sda_oe_n [*8])
		else $error("pull released early");
	AST_BUSY_NACK: assert property (write_busy |-> sda_oe_n)
		else $error("device drives while busy");
	AST_STANDBY_RELEASED: assert property (standby |-> sda_oe_n)
		else $error("driving in standby");
	AST_BUSY_NOT_STANDBY: assert property
		(write_busy && $past(write_busy) |-> !standby)
		else $error("standby during write");
	AST_BUSY_AFTER_STOP: assert property
		($rose(write_busy) |-> scl && sda_in && !$past(sda_in, 10))
		else $error("write not started by stop");
	AST_BUSY_LIMIT: assert property
		($fell(write_busy) |-> busy_cnt >= WR_CYCLES - 1 && busy_cnt <= WR_CYCLES)
		else $error("write cycle length wrong");
endmodule // tws_eeprom_checker

bind tws_eeprom tws_eeprom_checker #(.WR_CYCLES(WR_CYCLES)) i_tws_eeprom_checker
(
	.ref_clk(ref_clk), .nrst(nrst), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
	.sda_oe_n(sda_oe_n), .hw_addr_pin_hi(hw_addr_pin_hi), .hw_addr_pin_lo(hw_addr_pin_lo),
	.write_lock_pin(write_lock_pin), .standby(standby), .write_busy(write_busy)
);

// file: testbench/tb.sv
// Self-checking bench for the two-wire EEPROM slave
`timescale 1ns/100ps
module tb;
	import tws_pkg::*;
	localparam int WRC = 512;
	logic        ref_clk;
	logic        nrst;
	logic        scl;
	logic        sda_drv;
	wire logic   sda;
	logic        sda_out;
	logic        sda_oe_n;
	logic        hw_addr_pin_hi;
	logic        hw_addr_pin_lo;
	logic        write_lock_pin;
	logic        standby;
	logic        write_busy;
	logic        ack;
	logic [7:0]  rd;
	logic [7:0]  mem_exp [MEM_BYTES];
	logic [7:0]  bad [2] = '{{~DEV_TYPE_CODE, 4'h8}, {DEV_TYPE_CODE, 4'h4}};
	logic [16:0] rows [4] = '{{9'h000, 8'hA5}, {9'h0FF, 8'h3C}, {9'h100, 8'h5A}, {9'h1FF, 8'hC3}};
	int          errors = 0;
	int          samples_checked = 0;
	int          cycles = 0;
	int          polls;
	// Pull-up on the wire: low only while a party pulls it
	assign sda = sda_drv & (sda_oe_n | sda_out);
	tws_eeprom #(.WR_CYCLES(WRC)) i_tws_eeprom
	(
		.ref_clk(ref_clk), .nrst(nrst), .scl(scl), .sda_in(sda), .sda_out(sda_out),
		.sda_oe_n(sda_oe_n), .hw_addr_pin_hi(hw_addr_pin_hi), .hw_addr_pin_lo(hw_addr_pin_lo),
		.write_lock_pin(write_lock_pin), .standby(standby), .write_busy(write_busy)
	);
	tws_master i_tws_master (.scl(scl), .sda_drv(sda_drv), .sda(sda));
	initial
	begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	task automatic tally_and_finish;
		$display("Checks %0d, mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 60000)
		begin
			errors++;
			tally_and_finish;
		end
	end
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask
	function automatic logic [7:0] sa(input logic [8:0] a, input logic rd_n);
		return {DEV_TYPE_CODE, hw_addr_pin_hi, hw_addr_pin_lo, a[8], rd_n};
	endfunction
	task automatic wr(input logic [8:0] a, input int n, input logic [7:0] d0);
		logic [8:0] p;
		p = a;
		i_tws_master.start();
		i_tws_master.send(sa(a, 1'b0), ack);
		check("addr ack", ack, 1'b1);
		i_tws_master.send(a[7:0], ack);
		check("word ack", ack, 1'b1);
		for (int i = 0; i < n; i++)
		begin
			i_tws_master.send(d0 + 8'(i), ack);
			check("data ack", ack, 1'b1);
			if (!write_lock_pin)
				mem_exp[p] = d0 + 8'(i);
			p[3:0] = p[3:0] + 4'h1;
		end
		i_tws_master.stop();
		check("busy", write_busy, 1'b1);
		polls = 0;
		ack = 1'b0;
		while (!ack && polls < 8)
		begin
			i_tws_master.start();
			i_tws_master.send(sa(a, 1'b0), ack);
			i_tws_master.stop();
			polls++;
		end
		check("polls", 8'(polls), 8'h02);
	endtask
	// Dummy write then repeated start, or a bare current read when cur is set
	task automatic rdseq(input logic [8:0] a, input int n, input logic cur);
		logic [8:0] p;
		p = a;
		i_tws_master.start();
		if (!cur)
		begin
			i_tws_master.send(sa(a, 1'b0), ack);
			i_tws_master.send(a[7:0], ack);
			i_tws_master.start();
		end
		i_tws_master.send(sa(a, 1'b1), ack);
		check("read ack", ack, 1'b1);
		for (int i = 0; i < n; i++)
		begin
			i_tws_master.recv(i < n - 1, rd);
			check("read data", rd, mem_exp[p]);
			p = p + 9'h001;
		end
		i_tws_master.stop();
	endtask
	initial
	begin
		nrst = 1'b0;
		hw_addr_pin_hi = 1'b1;
		hw_addr_pin_lo = 1'b0;
		write_lock_pin = 1'b0;
		repeat (16) @(posedge ref_clk);
		check("standby", standby, 1'b1);
		check("busy", write_busy, 1'b0);
		check("oe_n", sda_oe_n, 1'b1);
		#1 nrst = 1'b1;
		repeat (8) @(posedge ref_clk);
		foreach (rows[k])
		begin
			wr(rows[k][16:8], 1, rows[k][7:0]);
			rdseq(rows[k][16:8], 1, 1'b0);
		end
		rdseq(9'h1FF, 1, 1'b0);
		rdseq(9'h000, 1, 1'b1);
		rdseq(9'h1FF, 2, 1'b0);
		foreach (bad[k])
		begin
			i_tws_master.start();
			i_tws_master.send(bad[k], ack);
			check("bad addr ack", ack, 1'b0);
			i_tws_master.stop();
		end
		// Abort mid-byte, then a fresh start must resync
		i_tws_master.start();
		i_tws_master.send(sa(9'h120, 1'b0), ack);
		repeat (3) i_tws_master.put_bit(1'b0, ack);
		wr(9'h12E, 18, 8'h40);
		rdseq(9'h120, 1, 1'b1);
		rdseq(9'h120, 16, 1'b0);
		@(posedge ref_clk);
		#1 write_lock_pin = 1'b1;
		wr(9'h0FF, 1, 8'h11);
		@(posedge ref_clk);
		#1 write_lock_pin = 1'b0;
		rdseq(9'h0FF, 1, 1'b0);
		repeat (10) @(posedge ref_clk);
		check("standby", standby, 1'b1);
		tally_and_finish;
	end
endmodule // tb
